// ===== logic/boost_ctrl.sv
// Boost converter mode latch, enable gating and switching clock control
//
// Function
// - Latch cell mode from inductor pin at power-on
// - Two-cell mode: converter always disabled
// - Single-cell: disabled in sleep, else enabled
// - Cell mode changes only at power-on reset
// - Select bit picks oscillator or system clock
// - Divider brings system clock into range
// - Invert bit inverts system clock before divider
// - Sleep disables converter, links output to battery
// - Float bit leaves output floating in sleep
// - Sync places tracking in quiet phase
`timescale 1ns/1ps
`include "boost_ctrl_regs.svh"

module boost_ctrl (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_por,
   input  wire logic        i_boost_inductor_pin,
   input  wire logic [1:0]  i_power_mode,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [11:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic [31:0]      o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   output logic             o_converter_enable,
   output logic             o_output_to_battery,
   output logic             o_converter_clk_en,
   output logic             o_sample_track_en
);
   // =========================================================
   // Declarations
   logic        single_cell_q;      // Latched cell mode, 1 = single
   logic        por_seen_q;         // Power-on reset capture pending
   logic [7:0]  control_q;          // Control register
   logic [7:0]  config_q;           // Config register
   logic        sleep;              // Power mode is sleep
   logic        enable_d;           // Next converter enable
   logic        link_d;             // Next output-to-battery link
   logic [3:0]  osc_cnt_q;          // Internal oscillator divider
   logic        osc_tick;           // Oscillator edge pulse
   logic        sys_phase_q;        // System path phase, invert-able
   logic [2:0]  div_cnt_q;          // System path divider count
   logic        sys_tick;           // Divided system path pulse
   logic        src_q;              // Active clock source
   logic        inv_q;              // Active invert setting
   logic        conv_phase_q;       // Converter clock phase
   boost_ctrl_pkg::switch_state_t sw_q; // Clock switch state
   logic        wr_en;              // APB write strobe
   logic        rd_hit;             // Address decodes

   assign sleep = (i_power_mode == boost_ctrl_pkg::PM_SLEEP);

   // =========================================================
   // Cell mode latch, captured only after power-on reset
   always_ff @(posedge i_clk or posedge i_por) begin
      if (i_por) begin
         por_seen_q    <= 1'b1;
         single_cell_q <= 1'b0;
      end else if (por_seen_q) begin
         // Inductor fitted reads high through inductor to battery
         single_cell_q <= i_boost_inductor_pin;
         por_seen_q    <= 1'b0;
      end
   end

   // =========================================================
   // APB register slave, zero wait states
   assign wr_en  = i_psel && i_penable && i_pwrite;
   assign rd_hit = (i_paddr == `ADDR_CONTROL) ||
                   (i_paddr == `ADDR_CONFIG) ||
                   (i_paddr == `ADDR_STATUS);

   // Register writes
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         control_q <= `CTRL_RESET;
         config_q  <= `CFG_RESET;
      end else if (wr_en) begin
         if (i_paddr == `ADDR_CONTROL) begin
            control_q <= i_pwdata[7:0];
         end
         if (i_paddr == `ADDR_CONFIG) begin
            // Top bit reserved, reads zero
            config_q <= i_pwdata[7:0] & `CFG_WMASK;
         end
      end
   end

   // Read data, ready and error
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_prdata  <= 32'h0000_0000;
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
      end else begin
         o_pready  <= i_psel && !i_penable;
         o_pslverr <= i_psel && !i_penable && !rd_hit;
         o_prdata  <= 32'h0000_0000;
         if (i_psel && !i_penable && !i_pwrite) begin
            case (i_paddr)
               `ADDR_CONTROL: o_prdata <= {24'h00_0000, control_q};
               `ADDR_CONFIG:  o_prdata <= {24'h00_0000, config_q};
               `ADDR_STATUS:  o_prdata <= {28'h000_0000, control_q[
                                 `CTRL_SYNC_BIT], o_output_to_battery,
                                 o_converter_enable, single_cell_q};
               default:       o_prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // =========================================================
   // Enable gating and sleep output link
   always_comb begin
      enable_d = single_cell_q && !sleep;
      link_d   = sleep && !config_q[`CFG_FLOAT_BIT];
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_converter_enable  <= 1'b0;
         o_output_to_battery <= 1'b0;
      end else begin
         o_converter_enable  <= enable_d;
         o_output_to_battery <= link_d;
      end
   end

   // =========================================================
   // Internal oscillator stand-in, half period rounded up from nominal rate
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         osc_cnt_q <= 4'h0;
      end else if (osc_cnt_q == 4'(`OSC_HALF_CYC - 1)) begin
         osc_cnt_q <= 4'h0;
      end else begin
         osc_cnt_q <= osc_cnt_q + 4'h1;
      end
   end
   assign osc_tick = (osc_cnt_q == 4'(`OSC_HALF_CYC - 1));

   // =========================================================
   // System path: optional inversion, then divider
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         sys_phase_q <= 1'b0;
         div_cnt_q   <= 3'h0;
      end else begin
         // Inverting shifts the divider phase by half a cycle
         sys_phase_q <= ~sys_phase_q;
         if (sys_phase_q ^ inv_q) begin
            // Wrap when the count reaches the programmed divider
            if (div_cnt_q >= {1'b0, config_q[`CFG_DIV_HI:`CFG_DIV_LO]}) begin
               div_cnt_q <= 3'h0;
            end else begin
               div_cnt_q <= div_cnt_q + 3'h1;
            end
         end
      end
   end
   // Tick every 2*(div+1) cycles; converter period is two ticks
   assign sys_tick = (sys_phase_q ^ inv_q) &&
      (div_cnt_q >= {1'b0, config_q[`CFG_DIV_HI:`CFG_DIV_LO]});

   // =========================================================
   // Glitch-free source switch: park low, swap, resume
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         sw_q         <= boost_ctrl_pkg::SW_RUN;
         src_q        <= 1'b0;
         inv_q        <= 1'b0;
         conv_phase_q <= 1'b0;
      end else begin
         case (sw_q)
            boost_ctrl_pkg::SW_RUN: begin
               if (src_q ? sys_tick : osc_tick) begin
                  conv_phase_q <= ~conv_phase_q;
               end
               if (src_q != config_q[`CFG_CONVERTER_CLOCK_SOURCE_SELECT_BIT] ||
                   inv_q != config_q[`CFG_INV_BIT]) begin
                  sw_q <= boost_ctrl_pkg::SW_PARK;
               end
            end
            boost_ctrl_pkg::SW_PARK: begin
               // Finish high phase of old source before swapping
               if (!conv_phase_q) begin
                  sw_q <= boost_ctrl_pkg::SW_LOAD;
               end else if (src_q ? sys_tick : osc_tick) begin
                  conv_phase_q <= 1'b0;
               end
            end
            boost_ctrl_pkg::SW_LOAD: begin
               src_q <= config_q[`CFG_CONVERTER_CLOCK_SOURCE_SELECT_BIT];
               inv_q <= config_q[`CFG_INV_BIT];
               sw_q  <= boost_ctrl_pkg::SW_RUN;
            end
            default: sw_q <= boost_ctrl_pkg::SW_RUN;
         endcase
      end
   end

   // =========================================================
   // Converter clock output and sampling window
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_converter_clk_en <= 1'b0;
         o_sample_track_en  <= 1'b0;
      end else begin
         o_converter_clk_en <= conv_phase_q && o_converter_enable;
         // Track only in quiet second half when synchronised
         if (control_q[`CTRL_SYNC_BIT] && o_converter_enable) begin
            o_sample_track_en <= !conv_phase_q;
         end else begin
            o_sample_track_en <= 1'b1;
         end
      end
   end
endmodule // boost_ctrl

// ===== logic/boost_ctrl_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef BOOST_CTRL_REGS_SVH
`define BOOST_CTRL_REGS_SVH
// Byte addresses on the APB register bus
`define ADDR_CONTROL     12'h000
`define ADDR_CONFIG      12'h004
`define ADDR_STATUS      12'h008
// Control register fields
`define CTRL_SYNC_BIT    3
`define CTRL_RESET       8'h21
// Config register fields
`define CFG_CONVERTER_CLOCK_SOURCE_SELECT_BIT   0
`define CFG_FLOAT_BIT    1
`define CFG_INV_BIT      3
`define CFG_DIV_LO       5
`define CFG_DIV_HI       6
`define CFG_RESET        8'h00
`define CFG_WMASK        8'h7f
// Status register fields
`define STAT_SINGLE_BIT  0
`define STAT_EN_BIT      1
`define STAT_LINK_BIT    2
`define STAT_SYNC_BIT    3
// Clock rates in MHz and kHz for timing derivations
`define SYS_CLK_MHZ      25
`define OSC_NOM_KHZ      2400
`define CONV_MIN_KHZ     1600
`define CONV_MAX_KHZ     3200
// Internal oscillator model: half period in system cycles
`define OSC_HALF_CYC     ((`SYS_CLK_MHZ * 1000 + 2 * `OSC_NOM_KHZ - 1) \
                          / (2 * `OSC_NOM_KHZ))
// Quiet window for sampling: second half of switching cycle
`define QUIET_OFFSET     1
`endif

// ===== logic/boost_ctrl_pkg.sv
// Types shared by the boost converter control block
package boost_ctrl_pkg;
   // Power modes seen by the converter
   typedef enum logic [1:0] {
      PM_NORMAL = 2'b00,
      PM_IDLE   = 2'b01,
      PM_SUSPND = 2'b10,
      PM_SLEEP  = 2'b11
   } power_mode_t;
   // Glitch-free clock switch state
   typedef enum logic [1:0] {
      SW_RUN   = 2'b00,
      SW_PARK  = 2'b01,
      SW_LOAD  = 2'b10
   } switch_state_t;
endpackage

// ===== tb/boost_ctrl_checker.sv
// Port assertions for the boost converter control block
`timescale 1ns/1ps
module boost_ctrl_checker (
   input wire logic        i_clk,
   input wire logic        i_rst,
   input wire logic        i_por,
   input wire logic        i_boost_inductor_pin,
   input wire logic [1:0]  i_power_mode,
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [31:0] o_prdata,
   input wire logic        o_pready,
   input wire logic        o_pslverr,
   input wire logic        o_converter_enable,
   input wire logic        o_output_to_battery,
   input wire logic        o_converter_clk_en,
   input wire logic        o_sample_track_en
);
   // ==========================================
   // Expected cell mode, caught after power-on
   logic cell_q;  // Single-cell expected
   logic arm_q;   // First edge still pending
   logic sleep;   // Sleep requested
   assign sleep = i_power_mode == boost_ctrl_pkg::PM_SLEEP;
   always_ff @(posedge i_clk or posedge i_por) begin
      if (i_por) begin
         cell_q <= 1'b0;
         arm_q  <= 1'b1;
      end else if (arm_q) begin
         cell_q <= i_boost_inductor_pin;
         arm_q  <= 1'b0;
      end
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // ==========================================
   // Assertions
   conv_enable_a: assert property (
      !$past(i_rst, 2) && !$past(i_rst) |->
      o_converter_enable == $past(cell_q && !sleep)) else $error("enable");
   two_cell_a: assert property (
      !arm_q && !cell_q |=> !o_converter_enable) else $error("two cell");
   sleep_off_a: assert property (
      sleep ##1 sleep |-> !o_converter_enable) else $error("sleep on");
   link_sleep_a: assert property (
      o_output_to_battery |-> $past(sleep)) else $error("link awake");
   clk_gate_a: assert property (
      !o_converter_enable [*3] |-> !o_converter_clk_en)
      else $error("clk gate");
   track_idle_a: assert property (
      !o_converter_enable [*3] |-> o_sample_track_en) else $error("track");
   clk_high_a: assert property (
      o_converter_enable && o_converter_clk_en |-> ##[1:40]
      (!o_converter_clk_en || !o_converter_enable)) else $error("clk high");
   clk_low_a: assert property (
      o_converter_enable && !o_converter_clk_en |-> ##[1:40]
      (o_converter_clk_en || !o_converter_enable)) else $error("clk low");
   no_runt_a: assert property (
      $changed(o_converter_clk_en) && o_converter_enable ##1 o_converter_enable
      |-> $stable(o_converter_clk_en)) else $error("runt pulse");
   cover property (o_pslverr);
   cover property (o_output_to_battery);
   cover property (o_converter_enable && $rose(o_converter_clk_en));
endmodule // boost_ctrl_checker

bind boost_ctrl boost_ctrl_checker chk_i (.*);

// ===== tb/tb_boost_ctrl.sv
// Self-checking bench for the boost converter control block
`timescale 1ns/1ps
module tb_boost_ctrl;
   // ==========================================
   // Stimulus, observed outputs, counters
   logic        clk = 1'b0, rst = 1'b1, por = 1'b1, pin = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [1:0]  mode = 2'b00;       // Power mode
   logic [11:0] paddr = 12'h000;    // Bus address
   logic [31:0] pwdata = 32'h0, rdata, prdata;
   logic        pready, pslverr, en, link, cclk, track, err;
   logic        rise_par, par0;     // Cycle parity of converter rises
   int          failures = 0, total_checks = 0, cycles = 0, rises = 0;
   // Rows: inductor pin, mode, enable, output link
   logic [4:0]  rows [8] = '{5'b1_00_1_0, 5'b1_01_1_0, 5'b1_10_1_0,
      5'b1_11_0_1, 5'b0_00_0_0, 5'b0_01_0_0, 5'b0_10_0_0, 5'b0_11_0_1};
   boost_ctrl dut (.i_clk(clk), .i_rst(rst), .i_por(por),
      .i_boost_inductor_pin(pin), .i_power_mode(mode), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
      .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .o_converter_enable(en),
      .o_output_to_battery(link), .o_converter_clk_en(cclk),
      .o_sample_track_en(track));
   always #20 clk = ~clk;
   always @(posedge cclk) begin
      rises++;
      rise_par = cycles[0];
   end
   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles > 20000) begin
         failures++;
         test_done();
      end
   end
   // ==========================================
   // Tasks
   task automatic test_done();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One APB transfer, held until pready is sampled
   task automatic apb(input logic w, input logic [11:0] a, input int d);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdata = prdata;
      err   = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic power_on(input logic p);
      @(posedge clk);
      por <= 1'b1;
      rst <= 1'b1;
      pin <= p;
      repeat (6) @(posedge clk);
      por <= 1'b0;
      rst <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   // Rising converter clock edges over 200 cycles, tracking phase too
   task automatic rate(input int cfg, input int lo);
      int bad;
      bad = 0;
      apb(1'b1, 12'h004, cfg);
      repeat (20) @(posedge clk);
      rises = 0;
      repeat (200) begin
         @(posedge clk);
         // With sync set, tracking only while the clock is low
         if (track === cclk) begin
            bad++;
         end
      end
      chk("clock rate", 1, rises >= lo && rises <= lo + 2);
      chk("track phase", 0, bad);
   endtask
   // ==========================================
   // Main sequence
   initial begin
      power_on(1'b1);
      foreach (rows[i]) begin
         if (rows[i][4] !== pin) power_on(rows[i][4]);
         @(posedge clk);
         mode <= rows[i][3:2];
         repeat (3) @(posedge clk);
         chk("enable", rows[i][1], en);
         chk("link", rows[i][0], link);
         apb(1'b0, 12'h008, 0);
         chk("status", {rows[i][0], rows[i][1], rows[i][4]}, rdata);
      end
      // Register reset alone keeps two-cell mode
      pin  <= 1'b1;
      rst  <= 1'b1;
      mode <= 2'b00;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      chk("kept two cell", 0, en);
      power_on(1'b1);
      apb(1'b0, 12'h000, 0);
      chk("ctrl reset", 32'h21, rdata);
      apb(1'b0, 12'h004, 0);
      chk("cfg reset", 32'h00, rdata);
      apb(1'b0, 12'h00c, 0);
      chk("unmapped err", 1, err);
      chk("unmapped data", 0, rdata);
      apb(1'b1, 12'h008, 32'hff);
      apb(1'b0, 12'h008, 0);
      chk("status ro", 32'h3, rdata);
      apb(1'b1, 12'h000, 32'h29);
      apb(1'b0, 12'h008, 0);
      chk("sync status", 32'hb, rdata);
      rate(32'h00, 16);
      rate(32'h61, 12);
      rate(32'h01, 49);
      par0 = rise_par;
      rate(32'h09, 49);
      chk("invert phase", !par0, rise_par);
      apb(1'b1, 12'h004, 32'hff);
      apb(1'b0, 12'h004, 0);
      chk("cfg mask", 32'h7f, rdata);
      mode <= 2'b11;
      repeat (4) @(posedge clk);
      chk("float link", 0, link);
      chk("sleep off", 0, en);
      test_done();
   end
endmodule // tb_boost_ctrl
